// ### design/fsk_dev_map.vh
// Purpose: register map and field layout of the fsk deviation control block
// Assumes: 7-bit register address, 16-bit data words on the serial port
// Notes: included by both design files
`ifndef FSK_DEV_MAP_VH
`define FSK_DEV_MAP_VH

`define ADDR_W 7
`define DATA_W 16
`define NUM_W 32
`define HDR_BITS 4'h7
`define WORD_BITS 4'hf

`define ADDR_APPLIED_STEP 7'h6e
`define ADDR_SERIAL_CTRL 7'h6f
`define ADDR_DIRECT_STEP 7'h71
`define ADDR_MOD_CTRL 7'h72
`define ADDR_INDEX_SELECT 7'h73
`define ADDR_LEVEL_FIRST 7'h74
`define ADDR_LEVEL_LAST 7'h7b

`define MOD_ENABLE_BIT 0
`define MOD_SOURCE_LSB 1
`define MOD_LEVELS_LSB 3
`define MOD_SHIFT_LSB 5
`define ADDR_HOLD_BIT 0

`define SOURCE_INDEXED 2'h2
`define SOURCE_DIRECT 2'h3

`define RESET_WORD 16'h0000
`define RESET_MOD_CTRL 16'h0000

`endif

// ### design/fsk_deviation_control.v
// Purpose: fsk deviation control, offsets the fractional numerator per step
// Assumes: nominal numerator comes from logic on core_clk; serial pins are async
// Notes: one numerator increment is one minimum frequency step
// Functional notes
// [RULE1] one step moves numerator by exactly one; code moves it by 2^deviation_shift
// [RULE2] host computes positive step counts by rounding
// [RULE3] host wraps negative steps as 2^16 minus count
// [RULE4] eight stored steps at consecutive addresses
// [RULE5] index select picks the stored step
// [RULE6] indexed mode: source 2 and enable set
// [RULE7] indexed mode limited to eight levels
// [RULE8] direct mode: source 3 applies written step
// [RULE9] address hold freezes address within a burst
// [RULE10] host oversamples waveform for shaped modulation
// [RULE11] step added as signed offset when enabled
// [RULE12] enable cleared returns nominal numerator
`default_nettype none
`include "fsk_dev_map.vh"

module fsk_deviation_control #(
  parameter LEVELS = 8
) (
  input wire core_clk,
  input wire reset,
  input wire serial_clk,
  input wire serial_data_in,
  input wire select_n,
  input wire [`NUM_W-1:0] nominal_numerator,
  output reg [`NUM_W-1:0] fraction_numerator,
  output reg serial_data_out,
  output reg serial_data_out_en_n
);

  reg [`DATA_W-1:0] stored_level [0:LEVELS-1];
  reg [`DATA_W-1:0] direct_step_field;
  reg [`DATA_W-1:0] mod_ctrl;
  reg [2:0] deviation_index_select;
  reg address_hold;
  reg [`DATA_W-1:0] applied_step;
  reg [`DATA_W-1:0] read_word;
  reg [`DATA_W-1:0] next_step;
  reg sel_meta;
  reg sel_seen;
  wire [`ADDR_W-1:0] reg_addr;
  wire [`DATA_W-1:0] write_word;
  wire write_strobe;
  wire port_sdo;
  wire modulation_enable;
  wire [1:0] modulation_source_select;
  wire [1:0] level_count_select;
  wire [2:0] deviation_shift;
  wire [2:0] level_index;
  integer i;

  assign modulation_enable = mod_ctrl[`MOD_ENABLE_BIT];
  assign modulation_source_select = mod_ctrl[`MOD_SOURCE_LSB+1:`MOD_SOURCE_LSB];
  assign level_count_select = mod_ctrl[`MOD_LEVELS_LSB+1:`MOD_LEVELS_LSB];
  assign deviation_shift = mod_ctrl[`MOD_SHIFT_LSB+2:`MOD_SHIFT_LSB];
  assign level_index = deviation_index_select & level_mask(level_count_select);

  // count select 0..3 gives 2, 4 (at 2 also 4), 8 levels; never more than eight
  function [2:0] level_mask;
    input [1:0] count_sel;
    begin
      case (count_sel)
        2'h0: level_mask = 3'h1;
        2'h1: level_mask = 3'h3;
        2'h2: level_mask = 3'h3; // [RULE7]
        default: level_mask = 3'h7; // [RULE7]
      endcase
    end
  endfunction

  function is_level_addr;
    input [`ADDR_W-1:0] addr;
    begin
      is_level_addr = (addr >= `ADDR_LEVEL_FIRST) && (addr <= `ADDR_LEVEL_LAST);
    end
  endfunction

  // level block starts off an 8-word boundary, so subtract before slicing
  function [2:0] level_slot;
    input [`ADDR_W-1:0] addr;
    reg [`ADDR_W-1:0] diff;
    begin
      diff = addr - `ADDR_LEVEL_FIRST;
      level_slot = diff[2:0];
    end
  endfunction

  // sign-extend first so a wrapped negative step stays negative after the shift
  function [`NUM_W-1:0] scaled_offset;
    input [`DATA_W-1:0] step;
    input [2:0] shift;
    reg [`NUM_W-1:0] wide;
    begin
      wide = {{(`NUM_W-`DATA_W){step[`DATA_W-1]}}, step};
      scaled_offset = wide << shift;
    end
  endfunction

  serial_reg_port port (
    .core_clk(core_clk),
    .reset(reset),
    .serial_clk(serial_clk),
    .serial_data_in(serial_data_in),
    .select_n(select_n),
    .address_hold(address_hold),
    .read_word(read_word),
    .reg_addr(reg_addr),
    .write_word(write_word),
    .write_strobe(write_strobe),
    .serial_data_out(port_sdo)
  );

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < LEVELS; i = i + 1) begin
        stored_level[i] <= `RESET_WORD;
      end
      direct_step_field <= `RESET_WORD;
      mod_ctrl <= `RESET_MOD_CTRL;
      deviation_index_select <= 3'h0;
      address_hold <= 1'b0;
    end else if (write_strobe) begin
      if (is_level_addr(reg_addr)) begin
        stored_level[level_slot(reg_addr)] <= write_word; // [RULE4]
      end
      case (reg_addr)
        `ADDR_DIRECT_STEP: direct_step_field <= write_word; // [RULE8]
        `ADDR_MOD_CTRL: mod_ctrl <= write_word;
        `ADDR_INDEX_SELECT: deviation_index_select <= write_word[2:0]; // [RULE5]
        `ADDR_SERIAL_CTRL: address_hold <= write_word[`ADDR_HOLD_BIT];
        default: ;
      endcase
    end
  end

  always @* begin
    next_step = `RESET_WORD;
    if (modulation_enable) begin
      case (modulation_source_select)
        `SOURCE_INDEXED: next_step = stored_level[level_index]; // [RULE5]
        `SOURCE_DIRECT: next_step = direct_step_field; // [RULE8]
        default: next_step = `RESET_WORD;
      endcase
    end
  end

  always @* begin
    read_word = `RESET_WORD;
    if (is_level_addr(reg_addr)) begin
      read_word = stored_level[level_slot(reg_addr)];
    end else begin
      case (reg_addr)
        `ADDR_DIRECT_STEP: read_word = direct_step_field;
        `ADDR_MOD_CTRL: read_word = mod_ctrl;
        `ADDR_INDEX_SELECT: read_word = {13'h0000, deviation_index_select};
        `ADDR_SERIAL_CTRL: read_word = {15'h0000, address_hold};
        `ADDR_APPLIED_STEP: read_word = applied_step;
        default: read_word = `RESET_WORD;
      endcase
    end
  end

  // select is a pin: two flops before the output enable may follow it
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sel_meta <= 1'b1;
      sel_seen <= 1'b1;
    end else begin
      sel_meta <= select_n;
      sel_seen <= sel_meta;
    end
  end

  // step is sign-extended, then scaled by the deviation shift
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      applied_step <= `RESET_WORD;
      fraction_numerator <= {`NUM_W{1'b0}};
      serial_data_out <= 1'b0;
      serial_data_out_en_n <= 1'b1;
    end else begin
      applied_step <= next_step;
      if (modulation_enable) begin
        fraction_numerator <= nominal_numerator +
          scaled_offset(applied_step, deviation_shift); // [RULE11] [RULE1]
      end else begin
        fraction_numerator <= nominal_numerator; // [RULE12]
      end
      serial_data_out <= port_sdo;
      serial_data_out_en_n <= sel_seen;
    end
  end

endmodule // fsk_deviation_control
`default_nettype wire

// ### design/serial_reg_port.v
// Purpose: serial register port, oversampled by the core clock
// Assumes: frame = read flag, 7 address bits, then 16-bit data words, msb first
// Notes: input sampled on serial clock rise, read data shifted out on fall
`default_nettype none
`include "fsk_dev_map.vh"

module serial_reg_port (
  input wire core_clk,
  input wire reset,
  input wire serial_clk,
  input wire serial_data_in,
  input wire select_n,
  input wire address_hold,
  input wire [`DATA_W-1:0] read_word,
  output reg [`ADDR_W-1:0] reg_addr,
  output reg [`DATA_W-1:0] write_word,
  output reg write_strobe,
  output reg serial_data_out
);

  reg [2:0] clk_sync;
  reg [1:0] data_sync;
  reg [1:0] sel_sync;
  reg [3:0] bit_count;
  reg header_done;
  reg read_frame;
  reg load_read;
  reg [`DATA_W-1:0] shift_in;
  reg [`DATA_W-1:0] shift_out;
  wire clk_rise;
  wire clk_fall;
  wire active;
  wire [`DATA_W-1:0] next_word;

  // only stage 1 and 2 of the sync chain feed any logic
  assign clk_rise = clk_sync[1] & ~clk_sync[2];
  assign clk_fall = ~clk_sync[1] & clk_sync[2];
  assign active = ~sel_sync[1];
  assign next_word = {shift_in[`DATA_W-2:0], data_sync[1]};

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      clk_sync <= 3'h0;
      data_sync <= 2'h0;
      sel_sync <= 2'h3;
    end else begin
      clk_sync <= {clk_sync[1:0], serial_clk};
      data_sync <= {data_sync[0], serial_data_in};
      sel_sync <= {sel_sync[0], select_n};
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bit_count <= 4'h0;
      header_done <= 1'b0;
      read_frame <= 1'b0;
      load_read <= 1'b0;
      shift_in <= `RESET_WORD;
      reg_addr <= {`ADDR_W{1'b0}};
      write_word <= `RESET_WORD;
      write_strobe <= 1'b0;
    end else begin
      write_strobe <= 1'b0;
      load_read <= 1'b0;
      if (!active) begin
        bit_count <= 4'h0;
        header_done <= 1'b0;
        read_frame <= 1'b0;
      end else if (clk_rise) begin
        shift_in <= next_word;
        bit_count <= bit_count + 4'h1;
        if (!header_done && bit_count == `HDR_BITS) begin
          read_frame <= shift_in[`ADDR_W-1];
          reg_addr <= next_word[`ADDR_W-1:0];
          header_done <= 1'b1;
          bit_count <= 4'h0;
          load_read <= 1'b1;
        end else if (header_done && bit_count == `WORD_BITS) begin
          write_word <= next_word;
          write_strobe <= ~read_frame;
          load_read <= 1'b1;
        end
      end else if (header_done && write_strobe) begin
        // frozen address keeps a burst on one register
        if (!address_hold) begin // [RULE9]
          reg_addr <= reg_addr + {{(`ADDR_W-1){1'b0}}, 1'b1};
        end
      end else if (header_done && read_frame && bit_count == 4'h0 && load_read) begin
        if (!address_hold) begin
          reg_addr <= reg_addr;
        end
      end
    end
  end

  // read data loads after each address settles, shifts out on falling edges
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shift_out <= `RESET_WORD;
      serial_data_out <= 1'b0;
    end else if (!active) begin
      serial_data_out <= 1'b0;
    end else if (load_read) begin
      shift_out <= read_word;
    end else if (clk_fall && read_frame) begin
      serial_data_out <= shift_out[`DATA_W-1];
      shift_out <= {shift_out[`DATA_W-2:0], 1'b0};
    end
  end

endmodule // serial_reg_port
`default_nettype wire

// ### sim/fsk_checker.sv
// Purpose: port checker for the deviation block
// Assumes: one core_clk domain
// Notes: idle means select_n high for 15 cycles
`default_nettype none
`include "fsk_dev_map.vh"
module fsk_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic select_n,
  input wire logic [`NUM_W-1:0] nominal_numerator,
  input wire logic [`NUM_W-1:0] fraction_numerator,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idle;
  logic [`NUM_W-1:0] nom_q;
  logic framed;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      idle <= 4'h0;
      nom_q <= 32'h0000_0000;
      framed <= 1'b0;
    end else begin
      idle <= select_n ? idle + {3'h0, idle != 4'hf} : 4'h0;
      nom_q <= nominal_numerator;
      framed <= framed | !select_n;
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  en_low_a: assert property (!select_n |-> ##3 !serial_data_out_en_n)
    else $error("en high");
  en_high_a: assert property (select_n |-> ##3 serial_data_out_en_n)
    else $error("en low");
  en_rise_a: assert property ($rose(serial_data_out_en_n) |-> $past(select_n, 3))
    else $error("en rose early");
  idle_zero_a: assert property (idle == 4'hf |-> !serial_data_out)
    else $error("out busy");
  hold_offset_a: assert property (idle == 4'hf |-> fraction_numerator - nom_q ==
    $past(fraction_numerator) - $past(nom_q)) else $error("offset moved");
  track_nom_a: assert property (idle == 4'hf && $changed(nominal_numerator) |=>
    fraction_numerator == $past(fraction_numerator) + nom_q - $past(nom_q)) else $error("lag");
  reset_nom_a: assert property (!framed |-> fraction_numerator == nom_q)
    else $error("offset after reset");
  idle_en_a: assert property (idle == 4'hf |-> serial_data_out_en_n [*2])
    else $error("en");
endmodule // fsk_checker
bind fsk_deviation_control fsk_checker fsk_checker_i (.core_clk, .reset, .select_n,
  .nominal_numerator, .fraction_numerator, .serial_data_out, .serial_data_out_en_n);
`default_nettype wire

// ### sim/host_serial_model.sv
// Purpose: host serial controller model for the register port
// Assumes: 320 ns serial clock, data set on fall, read on rise
// Notes: clock parked low and data line toggled outside frames
`default_nettype none
module host_serial_model (
  output logic serial_clk,
  output logic serial_data_in,
  output logic select_n,
  input wire logic serial_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rd = 16'h0000;
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    select_n = 1'b1;
  end
  task automatic bit_out(input logic b);
    serial_data_in = b;
    #160 serial_clk = 1'b1;
    rd = {rd[14:0], serial_data_out};
    #160 serial_clk = 1'b0;
  endtask
  // one step per word, as a sampled waveform needs
  task automatic frame(input logic [7:0] hdr, input logic [15:0] w [4], input int n);
    select_n = 1'b0;
    for (int i = 7; i >= 0; i--) bit_out(hdr[i]);
    for (int k = 0; k < n * 16; k++) bit_out(w[k / 16][15 - k % 16]);
    #160 select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #640;
  endtask
endmodule // host_serial_model
`default_nettype wire

// ### sim/tb_fsk_deviation_control.sv
// Purpose: self-checking bench for the deviation block
// Assumes: host model drives the serial port
// Notes: steps wait on the output with a bound
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_fsk_deviation_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] nom = 32'h0018_6a00;
  wire sclk;
  wire sdi;
  wire sel_n;
  wire sdo;
  wire sdo_en_n;
  wire [31:0] frac;
  int failures = 0;
  int checked = 0;
  // positive counts rounded, negative ones wrapped
  logic [15:0] lv [8] = '{16'h018c, 16'h040c, 16'h0500, 16'hfbf4,
    16'hfb00, 16'h0011, 16'h8000, 16'h7fff};
  always #20 core_clk = ~core_clk;
  host_serial_model host_serial_model_i (.serial_clk(sclk), .serial_data_in(sdi),
    .select_n(sel_n), .serial_data_out(sdo));
  fsk_deviation_control fsk_deviation_control_i (.core_clk(core_clk), .reset(reset),
    .serial_clk(sclk), .serial_data_in(sdi), .select_n(sel_n), .nominal_numerator(nom),
    .fraction_numerator(frac), .serial_data_out(sdo), .serial_data_out_en_n(sdo_en_n));
  task automatic final_report();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    host_serial_model_i.frame({1'b0, a}, '{d, 0, 0, 0}, 1);
  endtask
  task automatic expect_num(input logic [15:0] s, input int sh);
    logic [31:0] e;
    e = nom + ({{16{s[15]}}, s} << sh);
    for (int i = 0; i < 40 && frac !== e; i++) @(negedge core_clk);
    `CHK("fraction_numerator", e, frac)
    if (frac !== e) final_report();
  endtask
  task automatic t_direct();
    wr(7'h72, 16'h0007);
    wr(7'h71, 16'h0001);
    expect_num(16'h0001, 0);
    wr(7'h71, 16'hfbf4);
    expect_num(16'hfbf4, 0);
    wr(7'h72, 16'h0027);
    expect_num(16'hfbf4, 1);
    $display("test direct done");
  endtask
  task automatic t_hold();
    wr(7'h6f, 16'h0001);
    host_serial_model_i.frame(8'h71, '{16'h040c, 16'h0500, 16'hfbf4, 16'hfb00}, 4);
    expect_num(16'hfb00, 1);
    wr(7'h6f, 16'h0000);
    $display("test hold done");
  endtask
  task automatic t_indexed();
    host_serial_model_i.frame(8'h74, '{lv[0], lv[1], lv[2], lv[3]}, 4);
    host_serial_model_i.frame(8'h78, '{lv[4], lv[5], lv[6], lv[7]}, 4);
    wr(7'h72, 16'h001d);
    for (int i = 0; i < 8; i++) begin
      wr(7'h73, 16'(i));
      expect_num(lv[i], 0);
    end
    wr(7'h72, 16'h0015);
    wr(7'h73, 16'h0003);
    expect_num(lv[3], 0);
    wr(7'h10, 16'hffff);
    host_serial_model_i.frame(8'hfb, '{16'h0000, 0, 0, 0}, 1);
    `CHK("stored_level_7", lv[7], host_serial_model_i.rd)
    $display("test indexed done");
  endtask
  task automatic t_disable();
    wr(7'h72, 16'h0016);
    @(negedge core_clk);
    nom = 32'hffff_fff0;
    expect_num(16'h0000, 0);
    $display("test disable done");
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    repeat (4) @(negedge core_clk);
    `CHK("fraction_numerator", nom, frac)
    t_direct();
    t_hold();
    t_indexed();
    t_disable();
    final_report();
  end
endmodule // tb_fsk_deviation_control
`default_nettype wire
